//--- hdl/usdp_pkg.sv
// Constants, address map, field positions and line states of the UART shadow data port.
// Assumes a 32-bit APB slave at the fixed byte addresses below and a single 125 MHz clock.
package usdp_pkg;
   localparam int DATA_W = 8;
   localparam int FIFO_DEPTH = 16;
   localparam int DIV_W = 16;
   localparam int INT_W = 4;
   // Shadow window, sixteen aligned words
   localparam logic [31:0] ADDR_SHADOW_FIRST = 32'h5000_1030;
   localparam logic [31:0] ADDR_SHADOW_LAST = 32'h5000_106C;
   localparam logic [31:0] ADDR_SHADOW_SIX = 32'h5000_1048;
   localparam logic [31:0] ADDR_SHADOW_SEVEN = 32'h5000_104C;
   // Control and status words
   localparam logic [31:0] ADDR_CTRL = 32'h5000_1080;
   localparam logic [31:0] ADDR_LSR = 32'h5000_1084;
   localparam logic [31:0] ADDR_INT_STAT = 32'h5000_1088;
   localparam logic [31:0] ADDR_INT_MASK = 32'h5000_108C;
   localparam logic [31:0] ADDR_DIVISOR = 32'h5000_1090;
   // Control fields
   localparam int CTRL_FIFO_EN_BIT = 0;
   localparam int CTRL_IR_MODE_BIT = 1;
   // Line status fields
   localparam int LSR_DR_BIT = 0;
   localparam int LSR_OVR_BIT = 1;
   localparam int LSR_TX_HOLDING_EMPTY_FLAG_BIT = 5;
   localparam int LSR_TEMT_BIT = 6;
   // Interrupt fields
   localparam int INT_RX_BIT = 0;
   localparam int INT_OVR_BIT = 1;
   localparam int INT_TX_HOLDING_EMPTY_FLAG_BIT = 2;
   localparam int INT_TXDROP_BIT = 3;
   // Bit timing in oversample ticks
   localparam logic [3:0] OS_LAST = 4'hF;
   localparam logic [3:0] OS_SAMPLE = 4'h7;
   localparam logic [3:0] IR_PULSE_TICKS = 4'h3;
   localparam logic [2:0] BIT_LAST = 3'h7;
   localparam logic [DIV_W-1:0] DIV_RESET = 16'h0044;
   typedef enum logic [1:0] {USDP_IDLE, USDP_START, USDP_DATA, USDP_STOP} usdp_line_state_t;
endpackage

//--- hdl/usdp_fifo.sv
// Byte FIFO with flush, used for the receive and transmit queues.
// Assumes push is ignored while full and pop while empty.
`timescale 1ns/10ps
`default_nettype none
module usdp_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic reset,
   // Control
   input wire logic clear,
   input wire logic push,
   input wire logic [WIDTH-1:0] push_data,
   input wire logic pop,
   // Status
   output logic [WIDTH-1:0] head,
   output logic full,
   output logic empty
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam logic [AW-1:0] PTR_LAST = AW'(DEPTH - 1);
   localparam logic [AW:0] CNT_FULL = (AW + 1)'(DEPTH);

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0] wr;
      logic [AW-1:0] rd;
      logic [AW:0] cnt;
   } usdp_fifo_state_t;

   usdp_fifo_state_t st_q;
   usdp_fifo_state_t st_d;
   logic do_push;
   logic do_pop;

   assign full = (st_q.cnt == CNT_FULL);
   assign empty = (st_q.cnt == '0);
   assign head = st_q.mem[st_q.rd];

   always_comb begin
      st_d = st_q;
      do_push = push && !full;
      do_pop = pop && !empty;
      if (do_push) begin
         st_d.mem[st_q.wr] = push_data;
         st_d.wr = (st_q.wr == PTR_LAST) ? '0 : st_q.wr + 1'b1;
      end
      if (do_pop) begin
         st_d.rd = (st_q.rd == PTR_LAST) ? '0 : st_q.rd + 1'b1;
      end
      if (do_push && !do_pop) begin
         st_d.cnt = st_q.cnt + 1'b1;
      end else if (do_pop && !do_push) begin
         st_d.cnt = st_q.cnt - 1'b1;
      end
      if (clear) begin
         st_d.wr = '0;
         st_d.rd = '0;
         st_d.cnt = '0;
      end
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end
endmodule // usdp_fifo
`default_nettype wire

//--- hdl/usdp_top.sv
// UART shadow data port: APB slave, receive and transmit data paths, serial and infrared line.
// Assumes an APB master with held requests, serial inputs asynchronous to mclk.
//
// The APB slave port was decided locally.
`timescale 1ns/10ps
`default_nettype none
module usdp_top #(
   parameter int FIFO_DEPTH = usdp_pkg::FIFO_DEPTH
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic reset,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Serial line
   input wire logic sin,
   output logic sout,
   // Infrared line
   input wire logic sir_in,
   output logic sir_out_n,
   // Interrupt
   output logic irq
);
   typedef struct packed {
      logic pready;
      logic [31:0] prdata;
      logic pslverr;
      logic pop_ok;
      logic ovr_seen;
      logic fifo_en;
      logic ir_mode;
      logic [usdp_pkg::DIV_W-1:0] divisor;
      logic [usdp_pkg::DIV_W-1:0] div_cnt;
      logic [usdp_pkg::INT_W-1:0] int_stat;
      logic [usdp_pkg::INT_W-1:0] int_mask;
      logic irq;
      logic [usdp_pkg::DATA_W-1:0] rx_hold;
      logic rx_hold_full;
      logic [usdp_pkg::DATA_W-1:0] tx_hold;
      logic tx_hold_full;
      logic overrun;
      logic tx_holding_empty_flag_prev;
      usdp_pkg::usdp_line_state_t tx_state;
      logic [usdp_pkg::DATA_W-1:0] tx_shift;
      logic [2:0] tx_bit;
      logic [3:0] tx_os;
      logic sout;
      logic sir_out_n;
      usdp_pkg::usdp_line_state_t rx_state;
      logic [usdp_pkg::DATA_W-1:0] rx_shift;
      logic [2:0] rx_bit;
      logic [3:0] rx_os;
      logic ir_seen;
      logic sin_s1;
      logic sin_s2;
      logic sir_s1;
      logic sir_s2;
   } usdp_state_t;

   usdp_state_t st_q;
   usdp_state_t st_d;

   logic fifo_clear;
   logic rxf_push;
   logic rxf_pop;
   logic [usdp_pkg::DATA_W-1:0] rxf_data;
   logic [usdp_pkg::DATA_W-1:0] rxf_head;
   logic rxf_full;
   logic rxf_empty;
   logic txf_push;
   logic txf_pop;
   logic [usdp_pkg::DATA_W-1:0] txf_data;
   logic [usdp_pkg::DATA_W-1:0] txf_head;
   logic txf_full;
   logic txf_empty;

   usdp_fifo #(
      .WIDTH(usdp_pkg::DATA_W),
      .DEPTH(FIFO_DEPTH)
   ) u_rx_fifo (
      .mclk(mclk),
      .reset(reset),
      .clear(fifo_clear),
      .push(rxf_push),
      .push_data(rxf_data),
      .pop(rxf_pop),
      .head(rxf_head),
      .full(rxf_full),
      .empty(rxf_empty)
   );

   usdp_fifo #(
      .WIDTH(usdp_pkg::DATA_W),
      .DEPTH(FIFO_DEPTH)
   ) u_tx_fifo (
      .mclk(mclk),
      .reset(reset),
      .clear(fifo_clear),
      .push(txf_push),
      .push_data(txf_data),
      .pop(txf_pop),
      .head(txf_head),
      .full(txf_full),
      .empty(txf_empty)
   );

   assign prdata = st_q.prdata;
   assign pready = st_q.pready;
   assign pslverr = st_q.pslverr;
   assign sout = st_q.sout;
   assign sir_out_n = st_q.sir_out_n;
   assign irq = st_q.irq;

   always_comb begin
      logic access;
      logic commit;
      logic shadow_hit;
      logic mapped;
      logic data_ready;
      logic tx_holding_empty_flag;
      logic temt;
      logic tick;
      logic rx_line;
      logic rx_bit_val;
      logic rx_done;
      logic [usdp_pkg::INT_W-1:0] ev;
      logic [31:0] rd;
      logic [31:0] line_status_reg;
      access = 1'b0;
      commit = 1'b0;
      shadow_hit = 1'b0;
      mapped = 1'b0;
      data_ready = 1'b0;
      tx_holding_empty_flag = 1'b0;
      temt = 1'b0;
      tick = 1'b0;
      rx_line = 1'b0;
      rx_bit_val = 1'b0;
      rx_done = 1'b0;
      ev = '0;
      rd = '0;
      line_status_reg = '0;
      st_d = st_q;
      fifo_clear = 1'b0;
      rxf_push = 1'b0;
      rxf_pop = 1'b0;
      rxf_data = st_q.rx_shift;
      txf_push = 1'b0;
      txf_pop = 1'b0;
      txf_data = pwdata[usdp_pkg::DATA_W-1:0];

      // Input synchronisers
      st_d.sin_s1 = sin;
      st_d.sin_s2 = st_q.sin_s1;
      st_d.sir_s1 = sir_in;
      st_d.sir_s2 = st_q.sir_s1;

      // Line status
      data_ready = st_q.fifo_en ? !rxf_empty : st_q.rx_hold_full;
      tx_holding_empty_flag = st_q.fifo_en ? txf_empty : !st_q.tx_hold_full;
      temt = tx_holding_empty_flag && (st_q.tx_state == usdp_pkg::USDP_IDLE);
      line_status_reg[usdp_pkg::LSR_DR_BIT] = data_ready;
      line_status_reg[usdp_pkg::LSR_OVR_BIT] = st_q.overrun;
      line_status_reg[usdp_pkg::LSR_TX_HOLDING_EMPTY_FLAG_BIT] = tx_holding_empty_flag;
      line_status_reg[usdp_pkg::LSR_TEMT_BIT] = temt;

      // APB decode
      access = psel && penable && !st_q.pready;
      commit = psel && penable && st_q.pready;
      shadow_hit = (paddr >= usdp_pkg::ADDR_SHADOW_FIRST) && (paddr <= usdp_pkg::ADDR_SHADOW_LAST)
         && (paddr[1:0] == 2'h0);
      mapped = shadow_hit || (paddr == usdp_pkg::ADDR_CTRL) || (paddr == usdp_pkg::ADDR_LSR)
         || (paddr == usdp_pkg::ADDR_INT_STAT) || (paddr == usdp_pkg::ADDR_INT_MASK)
         || (paddr == usdp_pkg::ADDR_DIVISOR);
      st_d.pready = access;
      st_d.pslverr = access && !mapped;
      if (access) begin
         st_d.pop_ok = 1'b0;
         st_d.ovr_seen = 1'b0;
         if (shadow_hit) begin
            rd[usdp_pkg::DATA_W-1:0] = st_q.fifo_en ? rxf_head : st_q.rx_hold;
            st_d.pop_ok = data_ready;
         end else if (paddr == usdp_pkg::ADDR_CTRL) begin
            rd[usdp_pkg::CTRL_FIFO_EN_BIT] = st_q.fifo_en;
            rd[usdp_pkg::CTRL_IR_MODE_BIT] = st_q.ir_mode;
         end else if (paddr == usdp_pkg::ADDR_LSR) begin
            rd = line_status_reg;
            st_d.ovr_seen = st_q.overrun;
         end else if (paddr == usdp_pkg::ADDR_INT_STAT) begin
            rd[usdp_pkg::INT_W-1:0] = st_q.int_stat;
         end else if (paddr == usdp_pkg::ADDR_INT_MASK) begin
            rd[usdp_pkg::INT_W-1:0] = st_q.int_mask;
         end else if (paddr == usdp_pkg::ADDR_DIVISOR) begin
            rd[usdp_pkg::DIV_W-1:0] = st_q.divisor;
         end
         st_d.prdata = pwrite ? '0 : rd;
      end

      // Oversample tick divider
      if (st_q.div_cnt == '0) begin
         tick = 1'b1;
         st_d.div_cnt = st_q.divisor;
      end else begin
         st_d.div_cnt = st_q.div_cnt - 1'b1;
      end

      // Transmitter
      case (st_q.tx_state)
         usdp_pkg::USDP_IDLE: begin
            st_d.tx_os = '0;
            st_d.tx_bit = '0;
            if (st_q.fifo_en && !txf_empty) begin
               st_d.tx_shift = txf_head;
               txf_pop = 1'b1;
               st_d.tx_state = usdp_pkg::USDP_START;
            end else if (!st_q.fifo_en && st_q.tx_hold_full) begin
               st_d.tx_shift = st_q.tx_hold;
               st_d.tx_hold_full = 1'b0;
               st_d.tx_state = usdp_pkg::USDP_START;
            end
         end
         usdp_pkg::USDP_START: begin
            if (tick) begin
               st_d.tx_os = st_q.tx_os + 1'b1;
               if (st_q.tx_os == usdp_pkg::OS_LAST) begin
                  st_d.tx_state = usdp_pkg::USDP_DATA;
               end
            end
         end
         usdp_pkg::USDP_DATA: begin
            if (tick) begin
               st_d.tx_os = st_q.tx_os + 1'b1;
               if (st_q.tx_os == usdp_pkg::OS_LAST) begin
                  st_d.tx_shift = {1'b0, st_q.tx_shift[usdp_pkg::DATA_W-1:1]};
                  st_d.tx_bit = st_q.tx_bit + 1'b1;
                  if (st_q.tx_bit == usdp_pkg::BIT_LAST) begin
                     st_d.tx_state = usdp_pkg::USDP_STOP;
                  end
               end
            end
         end
         usdp_pkg::USDP_STOP: begin
            if (tick) begin
               st_d.tx_os = st_q.tx_os + 1'b1;
               if (st_q.tx_os == usdp_pkg::OS_LAST) begin
                  st_d.tx_state = usdp_pkg::USDP_IDLE;
               end
            end
         end
         default: begin
            st_d.tx_state = usdp_pkg::USDP_IDLE;
         end
      endcase

      // Line drivers: level in serial mode, short low pulse per zero bit in infrared mode
      rx_bit_val = (st_d.tx_state == usdp_pkg::USDP_START) ? 1'b0
         : (st_d.tx_state == usdp_pkg::USDP_DATA) ? st_d.tx_shift[0] : 1'b1;
      st_d.sout = st_q.ir_mode ? 1'b1 : rx_bit_val;
      st_d.sir_out_n = !(st_q.ir_mode && !rx_bit_val && (st_d.tx_os < usdp_pkg::IR_PULSE_TICKS));

      // Receiver
      rx_line = st_q.ir_mode ? !(st_q.ir_seen || st_q.sir_s2) : st_q.sin_s2;
      if (st_q.ir_mode && st_q.sir_s2) begin
         st_d.ir_seen = 1'b1;
      end
      case (st_q.rx_state)
         usdp_pkg::USDP_IDLE: begin
            st_d.rx_os = '0;
            st_d.rx_bit = '0;
            st_d.ir_seen = st_q.ir_mode && st_q.sir_s2;
            if (!rx_line) begin
               st_d.rx_state = usdp_pkg::USDP_START;
            end
         end
         usdp_pkg::USDP_START, usdp_pkg::USDP_DATA, usdp_pkg::USDP_STOP: begin
            if (tick) begin
               st_d.rx_os = st_q.rx_os + 1'b1;
               if (st_q.rx_os == usdp_pkg::OS_SAMPLE) begin
                  if (st_q.rx_state == usdp_pkg::USDP_START && rx_line) begin
                     st_d.rx_state = usdp_pkg::USDP_IDLE;
                  end else if (st_q.rx_state == usdp_pkg::USDP_DATA) begin
                     st_d.rx_shift = {rx_line, st_q.rx_shift[usdp_pkg::DATA_W-1:1]};
                  end else if (st_q.rx_state == usdp_pkg::USDP_STOP) begin
                     rx_done = 1'b1;
                     st_d.rx_state = usdp_pkg::USDP_IDLE;
                  end
               end
               if (st_q.rx_os == usdp_pkg::OS_LAST) begin
                  st_d.ir_seen = 1'b0;
                  if (st_q.rx_state == usdp_pkg::USDP_START) begin
                     st_d.rx_state = usdp_pkg::USDP_DATA;
                  end else begin
                     st_d.rx_bit = st_q.rx_bit + 1'b1;
                     if (st_q.rx_bit == usdp_pkg::BIT_LAST) begin
                        st_d.rx_state = usdp_pkg::USDP_STOP;
                     end
                  end
               end
            end
         end
         default: begin
            st_d.rx_state = usdp_pkg::USDP_IDLE;
         end
      endcase

      // Reads: once a byte was returned, pop the FIFO head or empty the holding register; clear only the overrun that was shown
      if (commit && !pwrite && shadow_hit && st_q.pop_ok) begin
         if (st_q.fifo_en) begin
            rxf_pop = 1'b1;
         end else begin
            st_d.rx_hold_full = 1'b0;
         end
      end
      if (commit && !pwrite && st_q.ovr_seen) begin
         st_d.overrun = 1'b0;
      end

      // Received character delivery, after the read so a new byte wins, except a full FIFO popped in the same cycle drops it without overrun
      if (rx_done) begin
         ev[usdp_pkg::INT_RX_BIT] = 1'b1;
         if (st_q.fifo_en) begin
            if (rxf_full && !rxf_pop) begin
               ev[usdp_pkg::INT_OVR_BIT] = 1'b1;
               st_d.overrun = 1'b1;
            end else begin
               rxf_push = 1'b1;
            end
         end else begin
            if (st_d.rx_hold_full) begin
               ev[usdp_pkg::INT_OVR_BIT] = 1'b1;
               st_d.overrun = 1'b1;
            end
            st_d.rx_hold = st_d.rx_shift;
            st_d.rx_hold_full = 1'b1;
         end
      end

      // Writes
      if (commit && pwrite) begin
         if (shadow_hit) begin
            if (st_q.fifo_en) begin
               if (txf_full) begin
                  ev[usdp_pkg::INT_TXDROP_BIT] = 1'b1;
               end else begin
                  txf_push = 1'b1;
               end
            end else begin
               st_d.tx_hold = pwdata[usdp_pkg::DATA_W-1:0];
               st_d.tx_hold_full = 1'b1;
            end
         end else if (paddr == usdp_pkg::ADDR_CTRL) begin
            st_d.fifo_en = pwdata[usdp_pkg::CTRL_FIFO_EN_BIT];
            st_d.ir_mode = pwdata[usdp_pkg::CTRL_IR_MODE_BIT];
            if (pwdata[usdp_pkg::CTRL_FIFO_EN_BIT] != st_q.fifo_en) begin
               fifo_clear = 1'b1;
               st_d.rx_hold_full = 1'b0;
               st_d.tx_hold_full = 1'b0;
            end
         end else if (paddr == usdp_pkg::ADDR_INT_MASK) begin
            st_d.int_mask = pwdata[usdp_pkg::INT_W-1:0];
         end else if (paddr == usdp_pkg::ADDR_DIVISOR) begin
            st_d.divisor = pwdata[usdp_pkg::DIV_W-1:0];
         end
      end

      // Interrupt status: write one to clear, a new event wins
      st_d.tx_holding_empty_flag_prev = tx_holding_empty_flag;
      ev[usdp_pkg::INT_TX_HOLDING_EMPTY_FLAG_BIT] = tx_holding_empty_flag && !st_q.tx_holding_empty_flag_prev;
      if (commit && pwrite && (paddr == usdp_pkg::ADDR_INT_STAT)) begin
         st_d.int_stat = st_q.int_stat & ~pwdata[usdp_pkg::INT_W-1:0];
      end
      st_d.int_stat = st_d.int_stat | ev;
      st_d.irq = |(st_d.int_stat & st_d.int_mask);
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         st_q <= '0;
         st_q.divisor <= usdp_pkg::DIV_RESET;
         st_q.sout <= 1'b1;
         st_q.sir_out_n <= 1'b1;
         st_q.sin_s1 <= 1'b1;
         st_q.sin_s2 <= 1'b1;
         st_q.tx_holding_empty_flag_prev <= 1'b1;
         st_q.tx_state <= usdp_pkg::USDP_IDLE;
         st_q.rx_state <= usdp_pkg::USDP_IDLE;
      end else begin
         st_q <= st_d;
      end
   end
endmodule // usdp_top
`default_nettype wire

//--- testbench/usdp_asserts.sv
// Checker of the shadow data port, watching the top ports only.
// Assumes a bind onto usdp_top and an APB master that holds its request.
`timescale 1ns/10ps
`default_nettype none
module usdp_asserts #(
   parameter int FIFO_DEPTH = 16
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic reset,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // Lines and interrupt
   input wire logic sin,
   input wire logic sout,
   input wire logic sir_in,
   input wire logic sir_out_n,
   input wire logic irq
);
   logic ir_q;
   logic done;
   logic shadow;
   logic mapped;
   assign done = psel && penable && pready;
   assign shadow = (paddr >= usdp_pkg::ADDR_SHADOW_FIRST) && (paddr <= usdp_pkg::ADDR_SHADOW_LAST)
      && (paddr[1:0] == 2'h0);
   assign mapped = shadow || (paddr inside {usdp_pkg::ADDR_CTRL, usdp_pkg::ADDR_LSR, usdp_pkg::ADDR_INT_STAT,
      usdp_pkg::ADDR_INT_MASK, usdp_pkg::ADDR_DIVISOR});
   // Tracks the infrared mode bit from completed control writes
   always_ff @(posedge mclk) begin
      if (reset) ir_q <= 1'b0;
      else if (done && pwrite && paddr == usdp_pkg::ADDR_CTRL) ir_q <= pwdata[usdp_pkg::CTRL_IR_MODE_BIT];
   end
   default clocking cb @(posedge mclk); endclocking
   default disable iff (reset);
   a_ready_after_access: assert property ($rose(penable) && psel |=> pready)
      else $error("pready late");
   a_ready_one_cycle: assert property (pready |=> !pready)
      else $error("pready longer than one cycle");
   a_err_with_ready: assert property (pslverr |-> pready)
      else $error("pslverr without pready");
   a_shadow_decode: assert property (done |-> pslverr == !mapped)
      else $error("wrong decode of address");
   a_upper_bits_zero: assert property (done && !pwrite && shadow |-> prdata[31:8] == 24'h0)
      else $error("shadow upper bits not zero");
   a_start_bit_low: assert property ($fell(sout) |-> !sout [*8])
      else $error("start bit too short");
   a_ir_pulse_len: assert property ($fell(sir_out_n) |-> !sir_out_n [*3] ##[1:300] sir_out_n)
      else $error("infrared pulse length wrong");
   a_ir_sout_idle: assert property (ir_q && $past(ir_q, 2) |-> sout)
      else $error("sout active in infrared mode");
   a_uart_ir_idle: assert property (!ir_q && !$past(ir_q, 2) |-> sir_out_n)
      else $error("infrared output active in serial mode");
   a_irq_masked_off: assert property (done && pwrite && paddr == usdp_pkg::ADDR_INT_MASK && pwdata[3:0] == 4'h0
      |-> ##[1:3] !irq) else $error("irq stays high with mask zero");
   c_shadow_write: cover property (done && pwrite && shadow);
   c_unmapped: cover property (done && pslverr);
   c_ir_pulse: cover property ($fell(sir_out_n));
endmodule // usdp_asserts
bind usdp_top usdp_asserts #(.FIFO_DEPTH(FIFO_DEPTH)) u_usdp_asserts (.mclk(mclk), .reset(reset), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .sin(sin), .sout(sout), .sir_in(sir_in), .sir_out_n(sir_out_n), .irq(irq));
`default_nettype wire

//--- testbench/usdp_line_model.sv
// Far-end serial and infrared line partner of the shadow data port.
// Assumes 8N1 frames, LSB first, BIT mclk cycles per bit.
`timescale 1ns/10ps
`default_nettype none
module usdp_line_model #(
   parameter int BIT = 32
) (
   // Clock
   input wire logic mclk,
   // Towards the device
   output logic sin,
   output logic sir_in,
   // From the device
   input wire logic sout,
   input wire logic sir_out_n
);
   initial begin
      sin = 1'b1;
      sir_in = 1'b0;
   end
   // Sends one frame, infrared pulse on zero bits when ir is set
   task automatic send(input logic [7:0] b, input logic ir);
      logic [9:0] f;
      f = {1'b1, b, 1'b0};
      for (int i = 0; i < 10; i++) begin
         @(posedge mclk);
         sin <= ir | f[i];
         sir_in <= ir & !f[i];
         repeat (BIT / 8) @(posedge mclk);
         sir_in <= 1'b0;
         repeat (BIT - BIT / 8 - 1) @(posedge mclk);
      end
   endtask
   // Takes one frame, early in each bit for infrared pulses
   task automatic recv(input logic ir, output logic [7:0] b);
      if (ir) @(negedge sir_out_n);
      else @(negedge sout);
      repeat (ir ? 2 : BIT / 2) @(posedge mclk);
      for (int i = 0; i < 8; i++) begin
         repeat (BIT) @(posedge mclk);
         b[i] = ir ? sir_out_n : sout;
      end
   endtask
endmodule // usdp_line_model
`default_nettype wire

//--- testbench/usdp_top_tb.sv
// Self-checking bench of the shadow data port.
// Assumes usdp_top with a small FIFO and the line model as far end.
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin mismatches++; $display("[ERR] %s exp %h got %h", n, e, g); end end
module usdp_top_tb;
   localparam int DEPTH = 4;
   localparam int BIT = 32;
   logic mclk, reset, psel, penable, pwrite, pready, pslverr, sin, sout, sir_in, sir_out_n, irq, err;
   logic [31:0] paddr, pwdata, prdata, rd;
   int mismatches, num_checks;
   usdp_top #(.FIFO_DEPTH(DEPTH)) u_usdp_top (.mclk(mclk), .reset(reset), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .sin(sin), .sout(sout), .sir_in(sir_in), .sir_out_n(sir_out_n), .irq(irq));
   usdp_line_model #(.BIT(BIT)) u_usdp_line_model (.mclk(mclk), .sin(sin), .sir_in(sir_in), .sout(sout),
      .sir_out_n(sir_out_n));
   initial begin
      mclk = 1'b0;
      forever #4 mclk = ~mclk;
   end
   task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge mclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      do begin
         @(posedge mclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rd = prdata;
      err = pslverr;
      if (n >= 20) mismatches++;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rchk(input logic [31:0] a, input logic [31:0] e, input logic [31:0] m, input string n);
      apb(1'b0, a, 32'h0);
      `CHK(n, e & m, rd & m)
   endtask
   task automatic t_reset();
      rchk(usdp_pkg::ADDR_SHADOW_SIX, 32'h0, '1, "six");
      rchk(usdp_pkg::ADDR_SHADOW_SEVEN, 32'h0, '1, "seven");
      rchk(usdp_pkg::ADDR_LSR, 32'h60, 32'h63, "lsr");
      rchk(usdp_pkg::ADDR_DIVISOR, 32'h44, 32'hFFFF, "div");
      apb(1'b0, 32'h5000_1000, 32'h0);
      `CHK("unmapped", 1'b1, err)
      apb(1'b1, usdp_pkg::ADDR_DIVISOR, 32'h1);
      // Old divisor count runs out before the short bit time applies
      repeat (int'(usdp_pkg::DIV_RESET) + 2) @(posedge mclk);
      $display("t_reset done");
   endtask
   task automatic t_tx();
      logic [7:0] x, y;
      rchk(usdp_pkg::ADDR_LSR, 32'h20, 32'h20, "tx_holding_empty_flag");
      fork
         begin
            u_usdp_line_model.recv(1'b0, x);
            u_usdp_line_model.recv(1'b0, y);
         end
         begin
            apb(1'b1, usdp_pkg::ADDR_SHADOW_SIX, 32'hFFFF_FFA5);
            apb(1'b1, usdp_pkg::ADDR_SHADOW_LAST, 32'h11);
            rchk(usdp_pkg::ADDR_LSR, 32'h0, 32'h20, "tx_holding_empty_flag_clr");
            apb(1'b1, usdp_pkg::ADDR_SHADOW_SEVEN, 32'h3C);
         end
      join
      `CHK("tx_first", 8'hA5, x)
      `CHK("tx_replaced", 8'h3C, y)
      $display("t_tx done");
   endtask
   task automatic t_rx();
      apb(1'b1, usdp_pkg::ADDR_INT_MASK, 32'h2);
      u_usdp_line_model.send(8'h3C, 1'b0);
      u_usdp_line_model.send(8'hC3, 1'b0);
      `CHK("irq", 1'b1, irq)
      rchk(usdp_pkg::ADDR_LSR, 32'h3, 32'h3, "dr_ovr");
      rchk(usdp_pkg::ADDR_SHADOW_SIX, 32'hC3, '1, "rx");
      rchk(usdp_pkg::ADDR_LSR, 32'h0, 32'h3, "dr_clr");
      apb(1'b1, usdp_pkg::ADDR_INT_MASK, 32'h0);
      rchk(usdp_pkg::ADDR_INT_STAT, 32'h2, 32'h2, "stat");
      `CHK("irq_mask", 1'b0, irq)
      apb(1'b1, usdp_pkg::ADDR_INT_STAT, 32'hF);
      apb(1'b1, usdp_pkg::ADDR_INT_MASK, 32'h2);
      rchk(usdp_pkg::ADDR_INT_STAT, 32'h0, 32'h2, "w1c");
      `CHK("irq_clr", 1'b0, irq)
      $display("t_rx done");
   endtask
   task automatic t_fifo_rx();
      apb(1'b1, usdp_pkg::ADDR_CTRL, 32'h1);
      for (int i = 0; i <= DEPTH; i++) u_usdp_line_model.send(8'h40 + i[7:0], 1'b0);
      rchk(usdp_pkg::ADDR_LSR, 32'h3, 32'h3, "full_ovr");
      for (int i = 0; i < DEPTH; i++) rchk(usdp_pkg::ADDR_SHADOW_FIRST + 32'(4 * i), 32'h40 + i, '1, "head");
      rchk(usdp_pkg::ADDR_LSR, 32'h0, 32'h1, "drained");
      $display("t_fifo_rx done");
   endtask
   task automatic t_fifo_tx();
      logic [7:0] x;
      apb(1'b1, usdp_pkg::ADDR_INT_STAT, 32'hF);
      rchk(usdp_pkg::ADDR_LSR, 32'h20, 32'h20, "tx_holding_empty_flag_fifo");
      fork
         for (int i = 0; i <= DEPTH; i++) begin
            u_usdp_line_model.recv(1'b0, x);
            `CHK("fifo_tx", 8'h80 + i[7:0], x)
         end
         for (int i = 0; i < DEPTH + 3; i++) apb(1'b1, usdp_pkg::ADDR_SHADOW_FIRST + 32'(4 * i), 32'h80 + i);
      join
      repeat (2 * BIT) @(posedge mclk);
      rchk(usdp_pkg::ADDR_INT_STAT, 32'h8, 32'h8, "drop");
      rchk(usdp_pkg::ADDR_LSR, 32'h60, 32'h61, "tx_idle");
      $display("t_fifo_tx done");
   endtask
   task automatic t_ir();
      logic [7:0] x;
      apb(1'b1, usdp_pkg::ADDR_CTRL, 32'h2);
      u_usdp_line_model.send(8'h5A, 1'b1);
      rchk(usdp_pkg::ADDR_SHADOW_SIX, 32'h5A, '1, "ir_rx");
      fork
         u_usdp_line_model.recv(1'b1, x);
         apb(1'b1, usdp_pkg::ADDR_SHADOW_SEVEN, 32'h96);
      join
      `CHK("ir_tx", 8'h96, x)
      `CHK("ir_sout", 1'b1, sout)
      $display("t_ir done");
   endtask
   task automatic results();
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   initial begin
      {psel, penable, pwrite, paddr, pwdata} = '0;
      reset = 1'b1;
      repeat (10) @(posedge mclk);
      reset <= 1'b0;
      t_reset();
      t_tx();
      t_rx();
      t_fifo_rx();
      t_fifo_tx();
      t_ir();
      results();
   end
   initial begin
      repeat (40000) @(posedge mclk);
      mismatches++;
      results();
   end
endmodule // usdp_top_tb
`default_nettype wire
